// ==== hw/acr_map.svh ====
// Purpose: named offsets, field positions, reset values and codes
// Assumes: 8-bit registers on a 5-bit register address
// Notes:   included by the package and by every design file but the interface
`ifndef ACR_MAP_SVH
`define ACR_MAP_SVH

// register addresses
`define ACR_ADDR_W        5
`define ACR_ADDR_OFS_HI   5'h03
`define ACR_ADDR_OFS_LO   5'h04
`define ACR_ADDR_MAIN     5'h05
`define ACR_ADDR_DRV      5'h06

// reset values
`define ACR_MAIN_RST      8'h20
`define ACR_DRV_RST       8'h04
`define ACR_ZERO8         8'h00

// main control fields
`define ACR_MAIN_STAGGER  1
`define ACR_MAIN_EXTREF   2
`define ACR_MAIN_FMT      3
`define ACR_MAIN_SYNC     4
`define ACR_MAIN_SLEEP    6
`define ACR_MAIN_TEMP     7

// output driver fields
`define ACR_DRV_FORCE     1:0
`define ACR_DRV_CUR       3:2
`define ACR_DRV_TERM      5:4
`define ACR_DRV_MODE      7:6

// field codes
`define ACR_FORCE_LOW     2'h2
`define ACR_FORCE_HIGH    2'h3
`define ACR_CODE_0        2'h0
`define ACR_CODE_1        2'h1
`define ACR_CODE_2        2'h2
`define ACR_CODE_3        2'h3
`define ACR_MODE_NORMAL   2'h0

// driver current in tenths of a milliamp
`define ACR_CUR_2P5       6'h19
`define ACR_CUR_3P5       6'h23
`define ACR_CUR_4P5       6'h2d
`define ACR_CUR_5P5       6'h37

// termination in ohms, zero means off
`define ACR_TERM_OFF      8'h00
`define ACR_TERM_200      8'hc8
`define ACR_TERM_100      8'h64

// offset trim: 9-bit code, mid code gives zero, step in microvolts
`define ACR_TRIM_W        9
`define ACR_TRIM_MID      16'sh0100
`define ACR_TRIM_STEP_UV  16'sh0078

// sample word
`define ACR_DATA_W        12

`endif

// ==== hw/acr_pkg.sv ====
// Purpose: state types for the converter configuration slice
// Assumes: constants come from acr_map.svh
// Notes:   one packed struct per module holds all of its state
`include "acr_map.svh"

package acr_pkg;

  typedef struct packed {
    logic                     offset_hi;
    logic [7:0]               offset_lo;
    logic [7:0]               main_ctrl;
    logic [7:0]               drv_ctrl;
    logic [7:0]               rd_data;
    logic signed [15:0]       offset_uv;
    logic [5:0]               drive_ma_x10;
    logic [7:0]               term_ohm;
  } acr_regs_t;

  typedef struct packed {
    logic                     sync_meta;
    logic                     sync_s;
    logic                     sync_s3;
    logic [`ACR_DATA_W-1:0]   a_p1;
    logic [`ACR_DATA_W-1:0]   a_p2;
    logic [`ACR_DATA_W-1:0]   b_p1;
    logic [`ACR_DATA_W-1:0]   b_p2;
    logic [`ACR_DATA_W-1:0]   b_p3;
    logic [1:0]               ovr_p1;
    logic [1:0]               ovr_p2;
    logic                     ovr_b3;
    logic [`ACR_DATA_W-1:0]   data_a;
    logic [`ACR_DATA_W-1:0]   data_b;
    logic                     flag_a;
    logic                     flag_b;
    logic                     clk_level;
    logic                     clk_forced;
  } acr_stage_t;

endpackage : acr_pkg

// ==== hw/acr_out_if.sv ====
// Purpose: control levels from the register slice to the output stage
// Assumes: all signals are register outputs on the same clock
// Notes:   ctrl drives, stage listens
`timescale 1ns/1ps

interface acr_out_if;
  logic       stagger;
  logic       twos_comp;
  logic       sync_mode;
  logic       sleep;
  logic [1:0] force_code;

  modport ctrl  (output stagger, twos_comp, sync_mode, sleep, force_code);
  modport stage (input  stagger, twos_comp, sync_mode, sleep, force_code);
endinterface : acr_out_if

// ==== hw/acr_out_stage.sv ====
// Purpose: output word formatting, forcing, stagger and sync marker
// Assumes: core samples arrive on clock; the sync pin is asynchronous
// Notes:   samples are delayed two cycles so they line up with the pin
`timescale 1ns/1ps
`include "acr_map.svh"

module acr_out_stage
  import acr_pkg::*;
(
  // clock and reset
  input  wire logic                   clock,
  input  wire logic                   rst_n,
  // control
  acr_out_if.stage                    ctl,
  // converter core
  input  wire logic [`ACR_DATA_W-1:0] core_sample_a,
  input  wire logic [`ACR_DATA_W-1:0] core_sample_b,
  input  wire logic                   core_ovr_a,
  input  wire logic                   core_ovr_b,
  input  wire logic                   sync_pin,
  // output pins
  output logic      [`ACR_DATA_W-1:0] data_a,
  output logic      [`ACR_DATA_W-1:0] data_b,
  output logic                        overrange_flag_out_a,
  output logic                        overrange_flag_out_b,
  output logic                        out_clk_level,
  output logic                        out_clk_forced
);

  acr_stage_t st_q;
  acr_stage_t st_d;

  // offset binary to two's complement is a flip of the sign bit
  function automatic logic [`ACR_DATA_W-1:0] fmt(input logic [`ACR_DATA_W-1:0] s,
                                                  input logic twos);
    fmt = s;
    if (twos) begin
      fmt[`ACR_DATA_W-1] = ~s[`ACR_DATA_W-1];
    end
  endfunction : fmt

  // next state: align, format, force
  always_comb begin
    st_d = st_q;
    st_d.sync_meta = sync_pin;
    st_d.sync_s    = st_q.sync_meta;
    st_d.sync_s3   = st_q.sync_s;
    st_d.a_p1      = core_sample_a;
    st_d.a_p2      = st_q.a_p1;
    st_d.b_p1      = core_sample_b;
    st_d.b_p2      = st_q.b_p1;
    st_d.b_p3      = st_q.b_p2;
    st_d.ovr_p1    = {core_ovr_b, core_ovr_a};
    st_d.ovr_p2    = st_q.ovr_p1;
    st_d.ovr_b3    = st_q.ovr_p2[1];
    st_d.clk_forced = ctl.force_code[1];
    // level only means something while forced; code 01 is normal output
    st_d.clk_level  = (ctl.force_code == `ACR_FORCE_HIGH);
    if (ctl.force_code == `ACR_FORCE_LOW) begin
      st_d.data_a = '0;
      st_d.data_b = '0;
      st_d.flag_a = 1'b0;
      st_d.flag_b = 1'b0;
    end else if (ctl.force_code == `ACR_FORCE_HIGH) begin
      st_d.data_a = '1;
      st_d.data_b = '1;
      st_d.flag_a = 1'b1;
      st_d.flag_b = 1'b1;
    end else if (ctl.sleep) begin
      // sleeping core gives no valid samples, so hold the bus quiet
      st_d.data_a = '0;
      st_d.data_b = '0;
      st_d.flag_a = 1'b0;
      st_d.flag_b = 1'b0;
    end else begin
      st_d.data_a = fmt(st_q.a_p2, ctl.twos_comp);
      // bus b one word late when staggered
      st_d.data_b = fmt(ctl.stagger ? st_q.b_p3 : st_q.b_p2, ctl.twos_comp);
      // marker replaces overrange, aligned with the pin's sample
      st_d.flag_a = ctl.sync_mode ? st_q.sync_s : st_q.ovr_p2[0];
      st_d.flag_b = ctl.sync_mode ? (ctl.stagger ? st_q.sync_s3 : st_q.sync_s)
                                  : (ctl.stagger ? st_q.ovr_b3 : st_q.ovr_p2[1]);
    end
    if (!rst_n) begin
      st_d = '0;
    end
  end

  // state register
  always_ff @(posedge clock) begin
    st_q <= st_d;
  end

  assign data_a               = st_q.data_a;
  assign data_b               = st_q.data_b;
  assign overrange_flag_out_a = st_q.flag_a;
  assign overrange_flag_out_b = st_q.flag_b;
  assign out_clk_level        = st_q.clk_level;
  assign out_clk_forced       = st_q.clk_forced;

  // checks on the output path
  a_force_low: assert property (@(posedge clock) disable iff (!rst_n)
    (ctl.force_code == `ACR_FORCE_LOW) |=> (data_a == '0 && data_b == '0 &&
                                           out_clk_forced && !out_clk_level))
    else $error("forced low outputs not all zero");
  a_sync_marker: assert property (@(posedge clock) disable iff (!rst_n)
    ($past(ctl.sync_mode) && !$past(ctl.force_code[1]) && !$past(ctl.sleep) &&
     $past(rst_n, 3)) |-> (overrange_flag_out_a == $past(sync_pin, 3)))
    else $error("sync marker not aligned with its sample");
  a_fmt_twos: assert property (@(posedge clock) disable iff (!rst_n)
    ($past(ctl.twos_comp) && !$past(ctl.force_code[1]) && !$past(ctl.sleep) &&
     $past(rst_n, 3)) |-> (data_a == {~$past(core_sample_a[`ACR_DATA_W-1], 3),
                                      $past(core_sample_a[`ACR_DATA_W-2:0], 3)}))
    else $error("two's complement word wrong");
  a_stagger_b: assert property (@(posedge clock) disable iff (!rst_n)
    ($past(ctl.stagger) && !$past(ctl.twos_comp) && !$past(ctl.force_code[1]) &&
     !$past(ctl.sleep) && $past(rst_n, 4)) |-> (data_b == $past(core_sample_b, 4)))
    else $error("staggered bus b not one word late");
  c_force_high: cover property (@(posedge clock) disable iff (!rst_n)
    ctl.force_code == `ACR_FORCE_HIGH ##1 data_a == '1);
  c_sync_seen: cover property (@(posedge clock) disable iff (!rst_n)
    ctl.sync_mode && overrange_flag_out_a);

endmodule : acr_out_stage

// ==== hw/acr_config_regs.sv ====
// Purpose: offset trim, main control and output driver registers
// Assumes: serial framing decoded elsewhere into single-cycle strobes
// Notes:   trim default is loaded from factory fuses while reset is held
//
// How it works
// - offset low register holds trim bits 7:0
// - trim code maps to microvolts, 120 per step
// - trim default comes from factory fuse input
// - bit one staggers bus b behind a
// - bit three picks two's complement format
// - sync mode puts marker on overrange pins
// - marker aligned with sync pin's sample word
// - bit six puts device to sleep
// - bit seven runs temp sensor regardless sleep
// - force field drives outputs low or high
// - current field picks 2.5 to 5.5 mA
// - termination field picks off, 200, 100 ohms
// - output mode 00 means normal data
// - offset high bit zero holds trim msb
`timescale 1ns/1ps
`include "acr_map.svh"

module acr_config_regs
  import acr_pkg::*;
(
  // clock and reset
  input  wire logic                     clock,
  input  wire logic                     rst_n,
  input  wire logic                     reg_soft_reset,
  // register port
  input  wire logic [`ACR_ADDR_W-1:0]   reg_addr,
  input  wire logic                     reg_wr,
  input  wire logic                     reg_rd,
  input  wire logic [7:0]               reg_wdata,
  output logic      [7:0]               reg_rd_data,
  // factory fuses
  input  wire logic [`ACR_TRIM_W-1:0]   factory_trim,
  // converter core
  input  wire logic [`ACR_DATA_W-1:0]   core_sample_a,
  input  wire logic [`ACR_DATA_W-1:0]   core_sample_b,
  input  wire logic                     core_ovr_a,
  input  wire logic                     core_ovr_b,
  input  wire logic                     sync_pin,
  // output pins
  output logic      [`ACR_DATA_W-1:0]   data_a,
  output logic      [`ACR_DATA_W-1:0]   data_b,
  output logic                          overrange_flag_out_a,
  output logic                          overrange_flag_out_b,
  output logic                          out_clk_level,
  output logic                          out_clk_forced,
  // analog controls
  output logic      [`ACR_TRIM_W-1:0]   offset_trim,
  output logic signed [15:0]            offset_uv,
  output logic                          ext_ref_sel,
  output logic                          sleep_en,
  output logic                          temp_sensor_en,
  output logic      [5:0]               drive_ma_x10,
  output logic      [7:0]               term_ohm,
  output logic                          out_mode_normal
);

  acr_regs_t st_q;
  acr_regs_t st_d;
  logic      do_reset;
  logic [`ACR_TRIM_W-1:0] trim_d;

  acr_out_if ctl_if ();

  assign do_reset = !rst_n || reg_soft_reset;

  // next state: writes, read data, decoded analog settings
  always_comb begin
    st_d = st_q;
    if (reg_wr) begin
      case (reg_addr)
        `ACR_ADDR_OFS_HI: st_d.offset_hi = reg_wdata[0];
        `ACR_ADDR_OFS_LO: st_d.offset_lo = reg_wdata;
        // reserved bits stored as written; the host keeps them legal
        `ACR_ADDR_MAIN:   st_d.main_ctrl = reg_wdata;
        `ACR_ADDR_DRV:    st_d.drv_ctrl  = reg_wdata;
        default:          st_d.offset_lo = st_q.offset_lo;
      endcase
    end
    // read data registered; unmapped addresses answer zero
    if (reg_rd) begin
      case (reg_addr)
        `ACR_ADDR_OFS_HI: st_d.rd_data = {7'h00, st_q.offset_hi};
        `ACR_ADDR_OFS_LO: st_d.rd_data = st_q.offset_lo;
        `ACR_ADDR_MAIN:   st_d.rd_data = st_q.main_ctrl;
        `ACR_ADDR_DRV:    st_d.rd_data = st_q.drv_ctrl;
        default:          st_d.rd_data = `ACR_ZERO8;
      endcase
    end
    // fuse value reloaded on either reset, never a fixed constant
    if (do_reset) begin
      st_d.offset_hi = factory_trim[`ACR_TRIM_W-1];
      st_d.offset_lo = factory_trim[7:0];
      st_d.main_ctrl = `ACR_MAIN_RST;
      st_d.drv_ctrl  = `ACR_DRV_RST;
      st_d.rd_data   = `ACR_ZERO8;
    end
    trim_d = {st_d.offset_hi, st_d.offset_lo};
    // signed offset: code minus mid times step, same edge as the code
    st_d.offset_uv = ($signed({7'h00, trim_d}) - `ACR_TRIM_MID) * `ACR_TRIM_STEP_UV;
    case (st_d.drv_ctrl[`ACR_DRV_CUR])
      `ACR_CODE_0: st_d.drive_ma_x10 = `ACR_CUR_2P5;
      `ACR_CODE_1: st_d.drive_ma_x10 = `ACR_CUR_3P5;
      `ACR_CODE_2: st_d.drive_ma_x10 = `ACR_CUR_4P5;
      default:     st_d.drive_ma_x10 = `ACR_CUR_5P5;
    endcase
    case (st_d.drv_ctrl[`ACR_DRV_TERM])
      `ACR_CODE_2: st_d.term_ohm = `ACR_TERM_200;
      `ACR_CODE_3: st_d.term_ohm = `ACR_TERM_100;
      default:     st_d.term_ohm = `ACR_TERM_OFF;
    endcase
  end

  // state register
  always_ff @(posedge clock) begin
    st_q <= st_d;
  end

  // control levels to the output stage
  assign ctl_if.stagger    = st_q.main_ctrl[`ACR_MAIN_STAGGER];
  assign ctl_if.twos_comp  = st_q.main_ctrl[`ACR_MAIN_FMT];
  assign ctl_if.sync_mode  = st_q.main_ctrl[`ACR_MAIN_SYNC];
  assign ctl_if.sleep      = st_q.main_ctrl[`ACR_MAIN_SLEEP];
  assign ctl_if.force_code = st_q.drv_ctrl[`ACR_DRV_FORCE];

  // analog and status outputs from registers; out_mode_normal is a compare on the mode field
  assign reg_rd_data     = st_q.rd_data;
  assign offset_trim     = {st_q.offset_hi, st_q.offset_lo};
  assign offset_uv       = st_q.offset_uv;
  assign ext_ref_sel     = st_q.main_ctrl[`ACR_MAIN_EXTREF];
  assign sleep_en        = st_q.main_ctrl[`ACR_MAIN_SLEEP];
  // sensor enable ignores sleep so temperature stays readable
  assign temp_sensor_en  = st_q.main_ctrl[`ACR_MAIN_TEMP];
  assign drive_ma_x10    = st_q.drive_ma_x10;
  assign term_ohm        = st_q.term_ohm;
  assign out_mode_normal = (st_q.drv_ctrl[`ACR_DRV_MODE] == `ACR_MODE_NORMAL);

  acr_out_stage u_stage (
    .clock                (clock),
    .rst_n                (rst_n),
    .ctl                  (ctl_if.stage),
    .core_sample_a        (core_sample_a),
    .core_sample_b        (core_sample_b),
    .core_ovr_a           (core_ovr_a),
    .core_ovr_b           (core_ovr_b),
    .sync_pin             (sync_pin),
    .data_a               (data_a),
    .data_b               (data_b),
    .overrange_flag_out_a (overrange_flag_out_a),
    .overrange_flag_out_b (overrange_flag_out_b),
    .out_clk_level        (out_clk_level),
    .out_clk_forced       (out_clk_forced)
  );

  // register checks
  a_trim_low: assert property (@(posedge clock) disable iff (!rst_n)
    (reg_wr && !reg_soft_reset && reg_addr == `ACR_ADDR_OFS_LO) |=>
      (offset_trim[7:0] == $past(reg_wdata)))
    else $error("offset low not stored");
  a_trim_msb: assert property (@(posedge clock) disable iff (!rst_n)
    (reg_wr && !reg_soft_reset && reg_addr == `ACR_ADDR_OFS_HI) |=>
      (offset_trim[`ACR_TRIM_W-1] == $past(reg_wdata[0])))
    else $error("offset msb not stored");
  a_factory_load: assert property (@(posedge clock)
    (!rst_n) |=> (offset_trim == $past(factory_trim)))
    else $error("factory trim not loaded at reset");
  a_soft_defaults: assert property (@(posedge clock) disable iff (!rst_n)
    reg_soft_reset |=> (st_q.main_ctrl == `ACR_MAIN_RST && st_q.drv_ctrl == `ACR_DRV_RST &&
                        drive_ma_x10 == `ACR_CUR_3P5 && term_ohm == `ACR_TERM_OFF))
    else $error("register reset left non-default values");
  a_offset_map: assert property (@(posedge clock) disable iff (!rst_n)
    (offset_trim == 9'h000) |-> (offset_uv == -16'sd30720))
    else $error("lowest trim code not at minus end");
  a_offset_top: assert property (@(posedge clock) disable iff (!rst_n)
    (offset_trim == 9'h1ff) |-> (offset_uv == 16'sd30600))
    else $error("highest trim code not at plus end");
  a_cur_code: assert property (@(posedge clock) disable iff (!rst_n)
    (st_q.drv_ctrl[`ACR_DRV_CUR] == `ACR_CODE_2) |-> (drive_ma_x10 == `ACR_CUR_4P5))
    else $error("current code 10 not 4.5 mA");
  a_term_code: assert property (@(posedge clock) disable iff (!rst_n)
    (st_q.drv_ctrl[`ACR_DRV_TERM] == `ACR_CODE_3) |-> (term_ohm == `ACR_TERM_100))
    else $error("termination code 11 not 100 ohms");
  a_temp_sleep: assert property (@(posedge clock) disable iff (!rst_n)
    (reg_wr && !reg_soft_reset && reg_addr == `ACR_ADDR_MAIN) |=>
      (temp_sensor_en == $past(reg_wdata[7]) && sleep_en == $past(reg_wdata[6])))
    else $error("sleep or sensor bit not independent");
  a_cur_low: assert property (@(posedge clock) disable iff (!rst_n)
    (st_q.drv_ctrl[`ACR_DRV_CUR] == `ACR_CODE_0) |-> (drive_ma_x10 == `ACR_CUR_2P5))
    else $error("current code 00 not 2.5 mA");

  // control bits reach the output stage one edge after the write
  a_ctl_bits: assert property (@(posedge clock) disable iff (!rst_n)
    (reg_wr && !reg_soft_reset && reg_addr == `ACR_ADDR_MAIN) |=>
      (ctl_if.stagger == $past(reg_wdata[`ACR_MAIN_STAGGER]) &&
       ctl_if.twos_comp == $past(reg_wdata[`ACR_MAIN_FMT])))
    else $error("stagger or format bit not passed on");
  a_sync_bit: assert property (@(posedge clock) disable iff (!rst_n)
    (reg_wr && !reg_soft_reset && reg_addr == `ACR_ADDR_MAIN) |=>
      (ctl_if.sync_mode == $past(reg_wdata[`ACR_MAIN_SYNC])))
    else $error("sync mode bit not passed on");
  a_force_bits: assert property (@(posedge clock) disable iff (!rst_n)
    (reg_wr && !reg_soft_reset && reg_addr == `ACR_ADDR_DRV) |=>
      (ctl_if.force_code == $past(reg_wdata[`ACR_DRV_FORCE])))
    else $error("force code not passed on");
  a_term_off: assert property (@(posedge clock) disable iff (!rst_n)
    (st_q.drv_ctrl[`ACR_DRV_TERM] < `ACR_CODE_2) |-> (term_ohm == `ACR_TERM_OFF))
    else $error("termination on for code 00 or 01");
  a_mode_flag: assert property (@(posedge clock) disable iff (!rst_n)
    (st_q.drv_ctrl[`ACR_DRV_MODE] != `ACR_MODE_NORMAL) |-> !out_mode_normal)
    else $error("output mode flag set for non-normal code");
  // host leaves idle cycles and other writes between, so allow a short gap
  c_main_write: cover property (@(posedge clock) disable iff (!rst_n)
    reg_wr && reg_addr == `ACR_ADDR_MAIN ##[1:4] reg_rd && reg_addr == `ACR_ADDR_MAIN);
  c_sleep_temp: cover property (@(posedge clock) disable iff (!rst_n)
    sleep_en && temp_sensor_en);

endmodule : acr_config_regs

// ==== tb/acr_host.sv ====
// Purpose: host side of the register port, single-cycle strobes
// Assumes: strobes change on the falling clock edge
// Notes:   released address and data show the inverse of the last value
`timescale 1ns/1ps
`include "acr_map.svh"

module acr_host (
  // clock
  input  wire logic                   clock,
  // register port
  output logic      [`ACR_ADDR_W-1:0] reg_addr,
  output logic                        reg_wr,
  output logic                        reg_rd,
  output logic      [7:0]             reg_wdata,
  input  wire logic [7:0]             reg_rd_data
);
  // idle bus at time zero
  initial begin
    reg_addr  = '0;
    reg_wr    = 1'b0;
    reg_rd    = 1'b0;
    reg_wdata = 8'h00;
  end

  // one write; reserved control bits are always fixed up by the host
  task automatic wr(input logic [`ACR_ADDR_W-1:0] a, input logic [7:0] d);
    @(negedge clock);
    reg_addr  = a;
    reg_wdata = (a == `ACR_ADDR_MAIN) ? ((d & 8'hfe) | 8'h20) : d;
    reg_wr    = 1'b1;
    @(negedge clock);
    reg_wr    = 1'b0;
    reg_addr  = ~reg_addr;  // stale lines must not look valid
    reg_wdata = ~reg_wdata;
  endtask : wr

  // one read; data is registered, taken one cycle after the strobe
  task automatic rd(input logic [`ACR_ADDR_W-1:0] a, output logic [7:0] d);
    @(negedge clock);
    reg_addr = a;
    reg_rd   = 1'b1;
    @(negedge clock);
    reg_rd   = 1'b0;
    reg_addr = ~reg_addr;
    d        = reg_rd_data;
  endtask : rd
endmodule : acr_host

// ==== tb/testbench.sv ====
// Purpose: self-checking bench for the converter configuration slice
// Assumes: inputs change on the falling edge; samples stream all the time
// Notes:   output words are checked against a history of driven samples
`timescale 1ns/1ps
`include "acr_map.svh"

module testbench;
  // clock, reset and inputs
  logic                   clock          = 1'b0;
  logic                   rst_n          = 1'b0;
  logic                   reg_soft_reset = 1'b0;
  logic [`ACR_ADDR_W-1:0] reg_addr;
  logic                   reg_wr, reg_rd;
  logic [7:0]             reg_wdata, reg_rd_data;
  logic [`ACR_TRIM_W-1:0] factory_trim;
  logic [11:0]            sa = '0, sb = '0;
  logic                   oa = 1'b0, ob = 1'b0, sp = 1'b0;
  // outputs
  logic [11:0]            data_a, data_b;
  logic                   flag_a, flag_b, clk_lv, clk_fc, ext_ref, sleep, temp, mode_n;
  logic [`ACR_TRIM_W-1:0] trim;
  logic signed [15:0]     uv;
  logic [5:0]             ma;
  logic [7:0]             ohm;
  // history (index 0 newest) and current mode
  logic [11:0]            ha [0:3], hb [0:3];
  logic [3:0]             hoa, hob, hs;
  logic [7:0]             m_cur  = 8'h20, dv_cur = 8'h04;
  logic                   chk_en = 1'b0;
  int                     n_mismatch = 0, check_count = 0;
  localparam logic [15:0] mode_tab [10] = '{16'h2004, 16'h2804, 16'h2204, 16'h2404,
      16'h3004, 16'h3a05, 16'h6004, 16'he004, 16'ha006, 16'h6007};

  always #5 clock = ~clock;

  acr_host i_acr_host (.clock(clock), .reg_addr(reg_addr), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_wdata(reg_wdata), .reg_rd_data(reg_rd_data));

  acr_config_regs i_acr_config_regs (.clock(clock), .rst_n(rst_n),
    .reg_soft_reset(reg_soft_reset), .reg_addr(reg_addr), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_wdata(reg_wdata), .reg_rd_data(reg_rd_data),
    .factory_trim(factory_trim), .core_sample_a(sa), .core_sample_b(sb),
    .core_ovr_a(oa), .core_ovr_b(ob), .sync_pin(sp), .data_a(data_a),
    .data_b(data_b), .overrange_flag_out_a(flag_a), .overrange_flag_out_b(flag_b),
    .out_clk_level(clk_lv), .out_clk_forced(clk_fc), .offset_trim(trim),
    .offset_uv(uv), .ext_ref_sel(ext_ref), .sleep_en(sleep),
    .temp_sensor_en(temp), .drive_ma_x10(ma), .term_ohm(ohm),
    .out_mode_normal(mode_n));

  task automatic chk_reg(input logic [7:0] got, input logic [7:0] exp);
    check_count++;
    if (got !== exp) begin
      n_mismatch++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk_reg

  task automatic chk_pin(input logic [15:0] got, input logic [15:0] exp);
    check_count++;
    if (got !== exp) begin
      n_mismatch++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk_pin

  // expected {flag, word}: format, then sleep blanking, then forcing wins
  function automatic logic [12:0] exp_out(input logic [11:0] s, input logic f);
    logic [12:0] r;
    r = {f, s[11] ^ m_cur[`ACR_MAIN_FMT], s[10:0]};
    if (m_cur[`ACR_MAIN_SLEEP]) r = '0;
    if (dv_cur[1]) r = {13{dv_cur[0]}};
    return r;
  endfunction : exp_out

  // check outputs against history, then launch the next random sample
  always @(negedge clock) begin
    if (chk_en) begin
      chk_pin({3'h0, flag_a, data_a}, {3'h0, exp_out(ha[2], m_cur[4] ? hs[2] : hoa[2])});
      chk_pin({3'h0, flag_b, data_b}, {3'h0, exp_out(hb[m_cur[1] ? 3 : 2],
        m_cur[4] ? hs[m_cur[1] ? 3 : 2] : hob[m_cur[1] ? 3 : 2])});
      chk_pin({14'h0, clk_fc, clk_lv}, {14'h0, dv_cur[1], &dv_cur[1:0]});
    end
    for (int i = 3; i > 0; i--) begin
      ha[i] = ha[i-1];
      hb[i] = hb[i-1];
    end
    sa    = 12'($urandom);
    sb    = 12'($urandom);
    oa    = 1'($urandom);
    ob    = 1'($urandom);
    sp    = ($urandom % 8) == 0;  // sparse marker pulses
    ha[0] = sa;
    hb[0] = sb;
    hoa   = {hoa[2:0], oa};
    hob   = {hob[2:0], ob};
    hs    = {hs[2:0], sp};
  end

  // register defaults after either kind of reset
  task automatic chk_defaults();
    logic [7:0] d;
    i_acr_host.rd(`ACR_ADDR_MAIN, d);
    chk_reg(d, `ACR_MAIN_RST);
    i_acr_host.rd(`ACR_ADDR_DRV, d);
    chk_reg(d, `ACR_DRV_RST);
    i_acr_host.rd(`ACR_ADDR_OFS_LO, d);
    chk_reg(d, factory_trim[7:0]);
    i_acr_host.rd(`ACR_ADDR_OFS_HI, d);
    chk_reg(d, {7'h00, factory_trim[8]});
    chk_pin({10'h000, ma}, {10'h000, `ACR_CUR_3P5});
  endtask : chk_defaults

  task automatic finish_test();
    $display("mismatches %0d, checks %0d", n_mismatch, check_count);
    if (n_mismatch == 0 && check_count > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : finish_test

  // watchdog, far beyond the expected run of under a thousand cycles
  initial begin
    #50000;
    n_mismatch++;
    finish_test();
  end

  initial begin
    logic [8:0] t;
    logic [7:0] d;
    void'($urandom(68964));
    factory_trim = 9'($urandom);
    repeat (8) @(negedge clock);
    rst_n = 1'b1;
    chk_defaults();
    // trim corners and random codes
    for (int i = 0; i < 6; i++) begin
      t = (i == 0) ? 9'h000 : (i == 1) ? 9'h1ff : 9'($urandom);
      i_acr_host.wr(`ACR_ADDR_OFS_HI, {7'h00, t[8]});
      i_acr_host.wr(`ACR_ADDR_OFS_LO, t[7:0]);
      repeat (2) @(negedge clock);
      chk_pin({7'h00, trim}, {7'h00, t});
      chk_pin(uv, 16'((int'(t) - 256) * 120));
      i_acr_host.rd(`ACR_ADDR_OFS_LO, d);
      chk_reg(d, t[7:0]);
    end
    // every current and termination code
    for (int c = 0; c < 4; c++) begin
      i_acr_host.wr(`ACR_ADDR_DRV, {2'h0, 2'(c), 2'(c), 2'h0});
      repeat (2) @(negedge clock);
      chk_pin({10'h000, ma}, 16'h0019 + 16'(c) * 16'h000a);
      chk_pin({8'h00, ohm}, (c == 2) ? 16'h00c8 : (c == 3) ? 16'h0064 : 16'h0000);
      chk_pin({15'h0, mode_n}, 16'h0001);
    end
    i_acr_host.wr(`ACR_ADDR_DRV, 8'h44);
    repeat (2) @(negedge clock);
    chk_pin({15'h0, mode_n}, 16'h0000);
    // output path in each control mode
    foreach (mode_tab[k]) begin
      chk_en = 1'b0;
      i_acr_host.wr(`ACR_ADDR_MAIN, mode_tab[k][15:8]);
      i_acr_host.wr(`ACR_ADDR_DRV, mode_tab[k][7:0]);
      m_cur  = mode_tab[k][15:8];
      dv_cur = mode_tab[k][7:0];
      i_acr_host.rd(`ACR_ADDR_MAIN, d);
      chk_reg(d, m_cur);
      chk_pin({13'h0, temp, sleep, ext_ref}, {13'h0, m_cur[7], m_cur[6], m_cur[2]});
      repeat (4) @(negedge clock);
      chk_en = 1'b1;
      repeat (40) @(negedge clock);
    end
    chk_en = 1'b0;
    // unmapped place reads zero, then register reset with a new fuse value
    i_acr_host.wr(5'h07, 8'hff);
    i_acr_host.rd(5'h07, d);
    chk_reg(d, 8'h00);
    factory_trim   = 9'($urandom);
    reg_soft_reset = 1'b1;
    @(negedge clock);
    reg_soft_reset = 1'b0;
    chk_defaults();
    finish_test();
  end
endmodule : testbench
